// ===== rtl/fieldbus_ctrl_pkg.sv
// Purpose: shared constants for the control byte decoder and live-bit watchdog
// Assumes: 25 MHz module clock, control bytes delivered by the fieldbus frame logic
// Notes: bit positions count from bit 0 of each control byte
package fieldbus_ctrl_pkg;

	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS = 40;

	// live-bit supervision window, in milliseconds as specified
	localparam int unsigned LIVE_TIMEOUT_MS = 1000;
	// a longest time rounds down to whole cycles
	localparam int unsigned LIVE_TIMEOUT_CYCLES = (CLK_HZ / 1000) * LIVE_TIMEOUT_MS;

	localparam int unsigned BYTE_W = 8;
	localparam int unsigned INDEX_W = 16;
	localparam int unsigned VALUE_W = 32;
	localparam int unsigned SPEED_W = 16;
	localparam int unsigned DRIFT_W = 16;
	localparam int unsigned NUM_PARAMS_DEF = 16;

	// second control byte
	localparam int unsigned AUX_LOOP_BIT = 3;
	localparam int unsigned SPEED_ONLY_BIT = 4;
	localparam int unsigned PSET_SELECT_BIT = 5;
	localparam int unsigned PDIR_INVERT_BIT = 6;
	localparam int unsigned PLOOP_ENABLE_BIT = 7;
	localparam logic [7:0] CTRL2_MASK = 8'hf8;

	// third control byte
	localparam int unsigned LIVE_BIT = 0;
	localparam int unsigned DRIFT_STORE_BIT = 5;
	localparam int unsigned DRIFT_COMP_BIT = 6;
	localparam int unsigned FINE_POS_BIT = 7;
	localparam logic [7:0] CTRL3_MASK = 8'he1;

	// fourth control byte
	localparam int unsigned PREAD_BIT = 5;
	localparam int unsigned PCOMMIT_BIT = 6;
	localparam int unsigned PMODE_BIT = 7;
	localparam logic [7:0] CTRL4_MASK = 8'he0;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [31:0] PARAM_MISSING = 32'hffffffff;
	localparam logic [31:0] PARAM_RESET = 32'h00000000;
	localparam logic [15:0] SPEED_FULL_SCALE = 16'h3fff;

endpackage

// ===== rtl/live_bit_watchdog.sv
// Purpose: supervises toggling of the master's live bit
// Assumes: live bit comes from a register on the same clock
// Notes: timeout stays set until the live bit changes again
`timescale 1ns/1ps
module live_bit_watchdog
	import fieldbus_ctrl_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = LIVE_TIMEOUT_CYCLES
)
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic live_bit_in,
	output logic armed_out,
	output logic timeout_out
);
	localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic prev;
		logic armed;
		logic timeout;
	} wd_state_t;

	wd_state_t st_r;
	wd_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.prev = live_bit_in;
		// monitoring starts only after the master first drives the bit true
		if (live_bit_in)
		begin
			st_nxt.armed = 1'b1;
		end
		if (live_bit_in != st_r.prev)
		begin
			st_nxt.cnt = '0;
			st_nxt.timeout = 1'b0;
		end
		else if (st_r.armed && !st_r.timeout)
		begin
			// master is expected to toggle within the window
			if (st_r.cnt == CNT_LAST)
			begin
				st_nxt.timeout = 1'b1;
			end
			else
			begin
				st_nxt.cnt = st_r.cnt + CNT_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign armed_out = st_r.armed;
	assign timeout_out = st_r.timeout;

	a_change_restarts: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		(live_bit_in != st_r.prev) |=> (st_r.cnt == '0) && !timeout_out)
	else $error("live bit change did not restart the watchdog");

	a_arm_before_trip: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!armed_out |-> !timeout_out && (st_r.cnt == '0))
	else $error("watchdog ran before being armed");

	a_trip_at_window: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		$rose(timeout_out) |-> $past(st_r.cnt) == CNT_LAST && $past(armed_out))
	else $error("watchdog tripped at the wrong count");

endmodule

// ===== rtl/fieldbus_control_bytes_livebit.sv
// Purpose: decodes control bytes 2..4 of the cyclic frame and runs the live-bit watchdog
// Assumes: frame logic on the same clock presents the received bytes with a one-cycle strobe
// Notes: parameter store is a small flip-flop table inside this block
`timescale 1ns/1ps
module fieldbus_control_bytes_livebit
	import fieldbus_ctrl_pkg::*;
#(
	parameter int unsigned NUM_PARAMS = NUM_PARAMS_DEF,
	parameter int unsigned LIVE_TIMEOUT = LIVE_TIMEOUT_CYCLES
)
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic frame_valid_in,
	input wire logic [BYTE_W-1:0] pressure_loop_control_in,
	input wire logic [BYTE_W-1:0] watchdog_drift_control_in,
	input wire logic [BYTE_W-1:0] parameter_access_control_in,
	input wire logic [INDEX_W-1:0] param_index_field_in,
	input wire logic [VALUE_W-1:0] param_value_field_in,
	input wire logic [SPEED_W-1:0] speed_setpoint1_in,
	input wire logic [DRIFT_W-1:0] drift_value_in,
	input wire logic system_enable_in,
	input wire logic error_in,
	output logic aux_loop_enable_out,
	output logic speed_limit_only_mode_out,
	output logic pressure_set_select_out,
	output logic pressure_direction_invert_out,
	output logic pressure_loop_enable_out,
	output logic drift_offset_store_out,
	output logic drift_comp_enable_out,
	output logic fine_position_enable_out,
	output logic param_mode_enable_out,
	output logic [SPEED_W-1:0] output_limit_out,
	output logic [DRIFT_W-1:0] drift_offset_out,
	output logic [VALUE_W-1:0] param_value_field_out,
	output logic live_bit_out,
	output logic ready_out
);

	typedef struct packed {
		logic [BYTE_W-1:0] ctrl2;
		logic [BYTE_W-1:0] ctrl3;
		logic [BYTE_W-1:0] ctrl4;
		logic [INDEX_W-1:0] index;
		logic [VALUE_W-1:0] wvalue;
		logic commit_prev;
		logic store_prev;
		logic [DRIFT_W-1:0] drift_offset;
		logic [SPEED_W-1:0] out_limit;
		logic [VALUE_W-1:0] rd_value;
		logic ready;
		logic [NUM_PARAMS-1:0][VALUE_W-1:0] params;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic wd_armed;
	logic wd_timeout;
	logic commit_edge;
	logic store_edge;
	logic index_hit;
	logic [VALUE_W-1:0] index_value;

	live_bit_watchdog #(
		.TIMEOUT_CYCLES(LIVE_TIMEOUT)
	) u_watchdog (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.live_bit_in(st_r.ctrl3[LIVE_BIT]),
		.armed_out(wd_armed),
		.timeout_out(wd_timeout)
	);

	// edges are taken on the stored bytes, so a write fires once per held frame level
	assign commit_edge = st_r.ctrl4[PCOMMIT_BIT] && !st_r.commit_prev;
	assign store_edge = st_r.ctrl3[DRIFT_STORE_BIT] && !st_r.store_prev;

	always_comb
	begin
		index_hit = 1'b0;
		index_value = PARAM_MISSING;
		for (int i = 0; i < NUM_PARAMS; i++)
		begin
			if (st_r.index == INDEX_W'(i))
			begin
				index_hit = 1'b1;
				index_value = st_r.params[i];
			end
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		if (frame_valid_in)
		begin
			// reserved bits are dropped here so nothing downstream can see them
			st_nxt.ctrl2 = pressure_loop_control_in & CTRL2_MASK;
			st_nxt.ctrl3 = watchdog_drift_control_in & CTRL3_MASK;
			st_nxt.ctrl4 = parameter_access_control_in & CTRL4_MASK;
			st_nxt.index = param_index_field_in;
			st_nxt.wvalue = param_value_field_in;
		end
		st_nxt.commit_prev = st_r.ctrl4[PCOMMIT_BIT];
		st_nxt.store_prev = st_r.ctrl3[DRIFT_STORE_BIT];

		// offset is frozen on the rising edge and held; a held bit does not keep resampling
		if (store_edge)
		begin
			st_nxt.drift_offset = drift_value_in;
		end

		if (st_r.ctrl2[SPEED_ONLY_BIT])
			st_nxt.out_limit = speed_setpoint1_in;
		else
			st_nxt.out_limit = SPEED_FULL_SCALE;

		// write to an address that does not exist is dropped silently
		for (int i = 0; i < NUM_PARAMS; i++)
		begin
			if (commit_edge && st_r.index == INDEX_W'(i))
			begin
				st_nxt.params[i] = st_r.wvalue;
			end
		end

		// read value holds its last answer while no read is requested
		if (st_r.ctrl4[PREAD_BIT])
		begin
			if (index_hit)
				st_nxt.rd_value = index_value;
			else
				st_nxt.rd_value = PARAM_MISSING;
		end

		st_nxt.ready = system_enable_in && !error_in && !wd_timeout;
	end

	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign aux_loop_enable_out = st_r.ctrl2[AUX_LOOP_BIT];
	assign speed_limit_only_mode_out = st_r.ctrl2[SPEED_ONLY_BIT];
	assign pressure_set_select_out = st_r.ctrl2[PSET_SELECT_BIT];
	assign pressure_direction_invert_out = st_r.ctrl2[PDIR_INVERT_BIT];
	assign pressure_loop_enable_out = st_r.ctrl2[PLOOP_ENABLE_BIT];
	assign drift_offset_store_out = st_r.ctrl3[DRIFT_STORE_BIT];
	assign drift_comp_enable_out = st_r.ctrl3[DRIFT_COMP_BIT];
	assign fine_position_enable_out = st_r.ctrl3[FINE_POS_BIT];
	assign param_mode_enable_out = st_r.ctrl4[PMODE_BIT];
	assign output_limit_out = st_r.out_limit;
	assign drift_offset_out = st_r.drift_offset;
	assign param_value_field_out = st_r.rd_value;
	assign live_bit_out = st_r.ctrl3[LIVE_BIT];
	assign ready_out = st_r.ready;

	a_aux_follows_frame: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=> aux_loop_enable_out == $past(pressure_loop_control_in[AUX_LOOP_BIT]))
	else $error("aux controller enable does not follow the frame");

	a_pressure_bits_track: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=>
			pressure_set_select_out == $past(pressure_loop_control_in[PSET_SELECT_BIT])
			&& pressure_direction_invert_out == $past(pressure_loop_control_in[PDIR_INVERT_BIT])
			&& pressure_loop_enable_out == $past(pressure_loop_control_in[PLOOP_ENABLE_BIT]))
	else $error("pressure controller bits do not follow the frame");

	a_bits_hold_between: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!frame_valid_in |=> $stable(pressure_loop_enable_out) && $stable(drift_comp_enable_out)
			&& $stable(fine_position_enable_out) && $stable(param_mode_enable_out))
	else $error("control bit changed without a frame");

	a_speed_limit_mode: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		speed_limit_only_mode_out |=> output_limit_out == $past(speed_setpoint1_in))
	else $error("output limit not taken from speed setpoint 1");

	a_full_scale_limit: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!speed_limit_only_mode_out |=> output_limit_out == SPEED_FULL_SCALE)
	else $error("output limited outside speed-only mode");

	a_drift_offset_store: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		$rose(drift_offset_store_out) |=> drift_offset_out == $past(drift_value_in))
	else $error("drift value not stored on store request");

	a_drift_offset_hold: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!store_edge |=> $stable(drift_offset_out))
	else $error("drift offset changed without a store edge");

	a_reserved_ignored: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=> (st_r.ctrl2 & ~CTRL2_MASK) == 8'h00
			&& (st_r.ctrl3 & ~CTRL3_MASK) == 8'h00 && (st_r.ctrl4 & ~CTRL4_MASK) == 8'h00)
	else $error("reserved control bit stored");

	a_read_missing: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		(st_r.ctrl4[PREAD_BIT] && st_r.index >= INDEX_W'(NUM_PARAMS))
			|=> param_value_field_out == PARAM_MISSING)
	else $error("unknown parameter address did not read as all ones");

	a_read_existing: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		(st_r.ctrl4[PREAD_BIT] && st_r.index < INDEX_W'(NUM_PARAMS))
			|=> param_value_field_out == $past(index_value))
	else $error("parameter read returned the wrong value");

	a_write_commit_edge: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		(commit_edge && st_r.index < INDEX_W'(NUM_PARAMS)) ##1 st_r.ctrl4[PREAD_BIT]
			&& st_r.index == $past(st_r.index)
			|=> param_value_field_out == $past(st_r.wvalue, 2))
	else $error("committed parameter not read back");

	a_no_write_level: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!commit_edge |=> $stable(st_r.params))
	else $error("parameter table changed without a commit edge");

	a_live_echo: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=> live_bit_out == $past(watchdog_drift_control_in[LIVE_BIT]))
	else $error("live bit not echoed");

	a_timeout_drops_ready: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		wd_timeout |=> !ready_out)
	else $error("ready kept after live-bit timeout");

	a_ready_cause: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		##1 ready_out == $past(system_enable_in && !error_in && !wd_timeout))
	else $error("ready does not match enable and error state");

	// arming lags the echoed live bit by one cycle, so only the previous echo must be clear
	a_idle_not_armed: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!wd_armed |-> !wd_timeout && !$past(live_bit_out))
	else $error("watchdog armed state inconsistent with live bit");

	a_speed_mode_track: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=>
			speed_limit_only_mode_out == $past(pressure_loop_control_in[SPEED_ONLY_BIT]))
	else $error("speed-only mode bit does not follow the frame");

	a_aux_hold: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!frame_valid_in |=> $stable(aux_loop_enable_out))
	else $error("aux controller enable changed without a frame");

	a_speed_mode_hold: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!frame_valid_in |=> $stable(speed_limit_only_mode_out))
	else $error("speed-only mode changed without a frame");

	a_set_select_hold: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!frame_valid_in |=> $stable(pressure_set_select_out))
	else $error("pressure parameter set changed without a frame");

	a_invert_track: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=>
			pressure_direction_invert_out == $past(pressure_loop_control_in[PDIR_INVERT_BIT]))
	else $error("pressure direction bit does not follow the frame");

	a_invert_hold: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!frame_valid_in |=> $stable(pressure_direction_invert_out))
	else $error("pressure direction changed without a frame");

	a_store_bit_track: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=>
			drift_offset_store_out == $past(watchdog_drift_control_in[DRIFT_STORE_BIT]))
	else $error("drift store bit does not follow the frame");

	a_drift_comp_track: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=>
			drift_comp_enable_out == $past(watchdog_drift_control_in[DRIFT_COMP_BIT]))
	else $error("drift compensation bit does not follow the frame");

	a_fine_pos_track: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=>
			fine_position_enable_out == $past(watchdog_drift_control_in[FINE_POS_BIT]))
	else $error("fine positioning bit does not follow the frame");

	a_param_mode_track: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		frame_valid_in |=>
			param_mode_enable_out == $past(parameter_access_control_in[PMODE_BIT]))
	else $error("parameterizing mode bit does not follow the frame");

	a_read_value_hold: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!st_r.ctrl4[PREAD_BIT] |=> $stable(param_value_field_out))
	else $error("read value changed without a read request");

	a_echo_hold: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		!frame_valid_in |=> $stable(live_bit_out))
	else $error("live bit echo changed without a frame");

	a_timeout_armed: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		wd_timeout |-> wd_armed)
	else $error("watchdog timed out while not armed");

	a_ready_on_enable: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		ready_out |-> $past(system_enable_in) && !$past(error_in))
	else $error("ready shown while disabled or in error");

	a_commit_single: assert property (
		@(posedge ref_clk_in) disable iff (reset_in)
		commit_edge |=> !commit_edge)
	else $error("write commit lasted more than one cycle");

endmodule

// ===== sim/fieldbus_master_model.sv
// Purpose: fieldbus master model that sends cyclic control frames
// Assumes: one frame is a one-cycle strobe on the module clock
// Notes: fields are inverted between frames, so the device must only sample on the strobe
`timescale 1ns/1ps
module fieldbus_master_model
	import fieldbus_ctrl_pkg::*;
(
	input wire logic ref_clk_in,
	output logic frame_valid_out,
	output logic [BYTE_W-1:0] byte2_out,
	output logic [BYTE_W-1:0] byte3_out,
	output logic [BYTE_W-1:0] byte4_out,
	output logic [INDEX_W-1:0] index_out,
	output logic [VALUE_W-1:0] value_out
);
	logic live_r = 1'b0;
	initial
	begin
		frame_valid_out = 1'b0;
		{byte2_out, byte3_out, byte4_out, index_out, value_out} = '0;
	end
	task automatic send(input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4,
		input logic [15:0] idx, input logic [31:0] val);
	begin
		@(posedge ref_clk_in);
		#1;
		frame_valid_out = 1'b1;
		byte2_out = b2;
		byte3_out = {b3[7:1], live_r};
		byte4_out = b4;
		index_out = idx;
		value_out = val;
		@(posedge ref_clk_in);
		#1;
		frame_valid_out = 1'b0;
		{byte2_out, byte3_out, byte4_out, index_out, value_out} =
			~{byte2_out, byte3_out, byte4_out, index_out, value_out};
	end
	endtask
	// one call flips the live bit once; the caller paces the calls
	task automatic toggle();
	begin
		live_r = ~live_r;
		send(8'h00, 8'h00, 8'h00, 16'h0000, 32'h00000000);
	end
	endtask
endmodule

// ===== sim/test_fieldbus_control_bytes_livebit.sv
// Purpose: self-checking bench for the control byte decoder and live-bit watchdog
// Assumes: frames come from the master model, levels are driven here
// Notes: watchdog span shortened to TMO cycles to keep the run short
`timescale 1ns/1ps
module test_fieldbus_control_bytes_livebit;
	import fieldbus_ctrl_pkg::*;
	localparam int unsigned NP = 8;
	localparam int unsigned TMO = 20;
	logic ref_clk_in = 1'b0, reset_in = 1'b1, fv;
	logic sys_en = 1'b0, err = 1'b0;
	logic [7:0] b2, b3, b4;
	logic [15:0] idx, speed = 16'h0abc, drift = 16'h1234;
	logic [31:0] val;
	logic aux, spd, pset, pdir, ploop, dstore, dcomp, fine, pmode, live, ready;
	logic [15:0] olim, doff;
	logic [31:0] pval;
	int error_cnt = 0;
	int checked = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	fieldbus_master_model i_master (.ref_clk_in(ref_clk_in), .frame_valid_out(fv),
		.byte2_out(b2), .byte3_out(b3), .byte4_out(b4), .index_out(idx), .value_out(val));
	fieldbus_control_bytes_livebit #(.NUM_PARAMS(NP), .LIVE_TIMEOUT(TMO)) i_dut (
		.ref_clk_in(ref_clk_in), .reset_in(reset_in), .frame_valid_in(fv),
		.pressure_loop_control_in(b2), .watchdog_drift_control_in(b3),
		.parameter_access_control_in(b4), .param_index_field_in(idx),
		.param_value_field_in(val), .speed_setpoint1_in(speed), .drift_value_in(drift),
		.system_enable_in(sys_en), .error_in(err), .aux_loop_enable_out(aux),
		.speed_limit_only_mode_out(spd), .pressure_set_select_out(pset),
		.pressure_direction_invert_out(pdir), .pressure_loop_enable_out(ploop),
		.drift_offset_store_out(dstore), .drift_comp_enable_out(dcomp),
		.fine_position_enable_out(fine), .param_mode_enable_out(pmode),
		.output_limit_out(olim), .drift_offset_out(doff), .param_value_field_out(pval),
		.live_bit_out(live), .ready_out(ready));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
	begin
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	end
	endtask
	task automatic settle(input int n);
	begin
		repeat (n) @(posedge ref_clk_in);
		#1;
	end
	endtask
	task automatic finish_test();
	begin
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task automatic t_reset();
	begin
		check("byte2 bits in reset", 32'({aux, spd, pset, pdir, ploop}), 32'h0);
		check("status in reset", 32'({dstore, dcomp, fine, pmode, live, ready}), 32'h0);
		check("words in reset", {olim, doff}, 32'h0);
		check("read value in reset", pval, 32'h0);
		settle(3);
		check("limit after reset", 32'(olim), 32'h3fff);
		$display("t_reset done");
	end
	endtask
	task automatic t_byte2();
	begin
		for (int i = 3; i < 8; i++)
		begin
			// reserved low bits set to see that they are dropped
			i_master.send(8'h07 | (8'h01 << i), 8'h1e, 8'h00, 16'h0000, 32'h0);
			settle(2);
			check("byte2 decode", 32'({ploop, pdir, pset, spd, aux}),
				32'(1 << (i - 3)));
			check("output limit", 32'(olim),
				(i == 4) ? 32'(speed) : 32'h3fff);
			check("byte3 idle", 32'({fine, dcomp, dstore}), 32'h0);
		end
		$display("t_byte2 done");
	end
	endtask
	task automatic t_byte3();
	begin
		for (int i = 5; i < 8; i++)
		begin
			i_master.send(8'h00, 8'h1e | (8'h01 << i), 8'h1f, 16'h0000, 32'h0);
			settle(2);
			check("byte3 decode", 32'({fine, dcomp, dstore}),
				32'(1 << (i - 5)));
			check("param mode idle", 32'(pmode), 32'h0);
		end
		i_master.send(8'h00, 8'h20, 8'h00, 16'h0000, 32'h0);
		settle(2);
		drift = 16'h5678;
		settle(3);
		check("drift offset held", 32'(doff), 32'h1234);
		$display("t_byte3 done");
	end
	endtask
	task automatic t_param();
	begin
		i_master.send(8'h00, 8'h00, 8'h80, 16'h0003, 32'h0);
		settle(2);
		check("param mode", 32'(pmode), 32'h1);
		i_master.send(8'h00, 8'h00, 8'h40, 16'h0003, 32'hcafe0001);
		// commit bit held high: second value must not be taken
		i_master.send(8'h00, 8'h00, 8'h60, 16'h0003, 32'h0badf00d);
		settle(3);
		check("readback", pval, 32'hcafe0001);
		i_master.send(8'h00, 8'h00, 8'h20, 16'(NP), 32'h0);
		settle(3);
		check("missing index", pval, PARAM_MISSING);
		// commit rises while the read bit stays set, so the new value shows up in the read field
		i_master.send(8'h00, 8'h00, 8'h60, 16'h0006, 32'h1234abcd);
		settle(3);
		check("write with read", pval, 32'h1234abcd);
		i_master.send(8'h00, 8'h00, 8'h20, 16'h0005, 32'h0);
		settle(3);
		check("unwritten entry", pval, 32'h0);
		i_master.send(8'h00, 8'h00, 8'h00, 16'h0003, 32'h0);
		settle(3);
		check("read value held", pval, 32'h0);
		$display("t_param done");
	end
	endtask
	task automatic t_live();
	begin
		sys_en = 1'b1;
		settle(TMO * 2);
		check("ready unarmed", 32'(ready), 32'h1);
		i_master.toggle();
		settle(1);
		check("live echo", 32'(live), 32'h1);
		for (int k = 0; k < 6; k++)
		begin
			settle(TMO / 2);
			i_master.toggle();
			check("live echo", 32'(live), 32'(k[0]));
			check("ready kept", 32'(ready), 32'h1);
		end
		settle(TMO + 6);
		check("ready timeout", 32'(ready), 32'h0);
		i_master.toggle();
		settle(3);
		check("ready back", 32'(ready), 32'h1);
		err = 1'b1;
		settle(2);
		check("ready error", 32'(ready), 32'h0);
		err = 1'b0;
		sys_en = 1'b0;
		settle(2);
		check("ready disabled", 32'(ready), 32'h0);
		$display("t_live done");
	end
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk_in);
		#1;
		t_reset_pre: check("live in reset", 32'(live), 32'h0);
		@(posedge ref_clk_in);
		#1;
		reset_in = 1'b0;
		t_reset();
		t_byte2();
		t_byte3();
		t_param();
		t_live();
		finish_test();
	end
	initial
	begin
		repeat (3000) @(posedge ref_clk_in);
		error_cnt++;
		finish_test();
	end
endmodule
